// file: hw/lsw_core.sv
// lamp switch mode, SPI, watchdog and output control core
`timescale 1ns/1ps
`include "lsw_consts.svh"
module lsw_core import lsw_pkg::*; #(
  parameter int STARTUP_CYC = `LSW_STARTUP_CYC,
  parameter int WATCHDOG_TIMEOUT_PERIOD_CYC    = `LSW_WATCHDOG_TIMEOUT_PERIOD_CYC,
  parameter int CAL_MIN_CYC = `LSW_CAL_MIN_CYC,
  parameter int CAL_MAX_CYC = `LSW_CAL_MAX_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic       SPI_CS_N,
  input  wire logic       SPI_SCLK,
  input  wire logic       SPI_SI,
  output logic            SPI_SO,
  output logic            SPI_SO_OE_N,
  input  wire logic       RESET_WAKE_PIN,
  input  wire logic       WAKE_PIN,
  input  wire logic [3:0] LAMP_REQUEST_PINS,
  input  wire logic       FAILSAFE_STRAP_PIN,
  input  wire logic       VDD_FAIL,
  input  wire logic [3:0] OVERCURRENT_FLAG,
  input  wire logic [3:0] OVERTEMP_FLAG,
  input  wire logic [3:0] SEVERE_SHORT_FLAG,
  input  wire logic [3:0] OPEN_LOAD_ON_FLAG,
  input  wire logic       BATTERY_LOW_FLAG,
  input  wire logic       SUPPLY_HIGH_FLAG,
  output logic [3:0]      LAMP_OUTPUTS,
  output logic            FAULT_FLAG_PIN_O,
  output logic            FAULT_FLAG_PIN_OE_N,
  output logic            NORMAL_MODE_FLAG
);
  // --------------------------------------------------
  // reset release
  // --------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // --------------------------------------------------
  // declarations
  // --------------------------------------------------
  lsw_mode_t   mode_reg;
  lsw_mode_t   mode_next;
  logic [5:0]  wsrc;
  logic [5:0]  wsrc_d_reg;
  logic        wake;
  logic        cs_d_reg;
  logic        sclk_d_reg;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_fall;
  logic        sclk_rise;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic [4:0]  bit_cnt_reg;
  logic        word_valid;
  logic [2:0]  waddr;
  logic [15:0] status;
  logic        ready;
  logic [12:0] start_cnt_reg;
  logic        cfg_wr;
  logic        cfg_clr;
  logic [3:0]  on_reg;
  logic [3:0]  dis_reg;
  logic        pwm_en_reg;
  logic        clk_sel_reg;
  logic        vdd_en_reg;
  logic        supply_high_protect_disable_reg;
  logic [6:0]  duty_reg [4];
  logic [2:0]  dly_reg [4];
  logic        cal_arm;
  logic        wd_arm_reg;
  logic [31:0] wd_cnt_reg;
  logic        wd_to_reg;
  logic        last_wd_reg;
  logic        fs_wd_reg;
  logic        fail_cond;
  logic        fail_d_reg;
  logic        exit_req;
  logic        fault_cond;
  logic [3:0]  oc_rep_reg;
  logic [3:0]  ot_rep_reg;
  logic [3:0]  ol_rep_reg;
  logic        uv_rep_reg;
  logic        ov_rep_reg;
  logic [3:0]  latch_reg;
  logic [3:0]  rearm;
  logic [3:0]  rearm_d_reg;
  logic [3:0]  cmd;
  logic [3:0]  hard_flt;
  logic        pwm_act;
  logic        pwm_tick;
  logic [6:0]  pwm_phase;
  logic        clk_fail;
  logic [3:0]  wave;

  // --------------------------------------------------
  // pin edges and wake-up
  // --------------------------------------------------
  assign wsrc      = {RESET_WAKE_PIN, WAKE_PIN, LAMP_REQUEST_PINS};
  assign wake      = |wsrc;
  assign cs_fall   = cs_d_reg & ~SPI_CS_N;
  assign cs_rise   = ~cs_d_reg & SPI_CS_N;
  assign sclk_fall = sclk_d_reg & ~SPI_SCLK;
  assign sclk_rise = ~sclk_d_reg & SPI_SCLK;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wsrc_d_reg <= 6'h00;
      cs_d_reg   <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      wsrc_d_reg <= wsrc;
      cs_d_reg   <= SPI_CS_N;
      sclk_d_reg <= SPI_SCLK;
    end
  end

  // --------------------------------------------------
  // SPI shift registers
  // --------------------------------------------------
  assign word_valid  = cs_rise && bit_cnt_reg == 5'h10;
  assign waddr       = rx_reg[`LSW_ADDR_HI:`LSW_ADDR_LO];
  assign SPI_SO      = tx_reg[15];
  assign SPI_SO_OE_N = SPI_CS_N;

  always_comb begin
    status = 16'h0000;
    status[`LSW_S_NM] = (mode_reg == LSW_NORMAL);
    status[`LSW_S_CF] = clk_fail;
    status[`LSW_S_UV] = uv_rep_reg;
    status[`LSW_S_OV] = ov_rep_reg;
    status[`LSW_S_OC +: 4] = oc_rep_reg;
    status[`LSW_S_OT +: 4] = ot_rep_reg;
    status[`LSW_S_OL +: 4] = ol_rep_reg;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg      <= 16'h0000;
      tx_reg      <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      tx_reg      <= status;
      bit_cnt_reg <= 5'h00;
    end else if (!SPI_CS_N) begin
      if (sclk_fall) begin
        rx_reg <= {rx_reg[14:0], SPI_SI};
        if (bit_cnt_reg != 5'h1F) bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end else if (sclk_rise && bit_cnt_reg != 5'h00) begin
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // --------------------------------------------------
  // start-up delay
  // --------------------------------------------------
  assign ready = (start_cnt_reg == 13'h0000);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) start_cnt_reg <= 13'(STARTUP_CYC);
    else if (mode_reg == LSW_SLEEP) start_cnt_reg <= 13'(STARTUP_CYC);
    else if (!ready) start_cnt_reg <= start_cnt_reg - 13'h0001;
  end

  // --------------------------------------------------
  // configuration registers
  // --------------------------------------------------
  assign cfg_wr  = word_valid && mode_reg == LSW_NORMAL && ready;
  assign cfg_clr = mode_reg != LSW_NORMAL || !ready;
  assign cal_arm = cfg_wr && waddr == `LSW_A_CAL && rx_reg[11:0] == `LSW_CAL_KEY;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      on_reg      <= 4'h0;
      dis_reg     <= 4'h0;
      pwm_en_reg  <= 1'b0;
      clk_sel_reg <= 1'b0;
      vdd_en_reg  <= 1'b0;
      supply_high_protect_disable_reg  <= 1'b0;
    end else if (cfg_clr) begin
      on_reg      <= 4'h0;
      dis_reg     <= 4'h0;
      pwm_en_reg  <= 1'b0;
      clk_sel_reg <= 1'b0;
      vdd_en_reg  <= 1'b0;
      supply_high_protect_disable_reg  <= 1'b0;
    end else if (cfg_wr && waddr == `LSW_A_CTRL) begin
      on_reg      <= rx_reg[`LSW_F_ON +: 4];
      dis_reg     <= rx_reg[`LSW_F_DIS +: 4];
      pwm_en_reg  <= rx_reg[`LSW_F_PWM_EN];
      clk_sel_reg <= rx_reg[`LSW_F_CLK_SEL];
      vdd_en_reg  <= rx_reg[`LSW_F_VDD_EN];
      supply_high_protect_disable_reg  <= rx_reg[`LSW_F_SUPPLY_HIGH_PROTECT_DISABLE];
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_duty
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        duty_reg[i] <= 7'h00;
        dly_reg[i]  <= 3'h0;
      end else if (cfg_clr) begin
        duty_reg[i] <= 7'h00;
        dly_reg[i]  <= 3'h0;
      end else if (cfg_wr && waddr == 3'(`LSW_A_DUTY0 + i)) begin
        duty_reg[i] <= rx_reg[`LSW_F_DUTY +: 7];
        dly_reg[i]  <= rx_reg[`LSW_F_DLY +: 3];
      end
    end
  end

  // --------------------------------------------------
  // watchdog
  // --------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wd_arm_reg <= 1'b0;
    end else if (mode_reg == LSW_SLEEP || !FAILSAFE_STRAP_PIN) begin
      wd_arm_reg <= 1'b0;
    end else if (|(wsrc & ~wsrc_d_reg)) begin
      wd_arm_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) last_wd_reg <= 1'b0;
    else if (mode_reg == LSW_SLEEP) last_wd_reg <= 1'b0;
    else if (word_valid) last_wd_reg <= rx_reg[`LSW_WD_BIT];
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_reg <= 32'h00000000;
      wd_to_reg  <= 1'b0;
    end else if (mode_reg != LSW_NORMAL || !wd_arm_reg) begin
      wd_cnt_reg <= 32'h00000000;
      wd_to_reg  <= 1'b0;
    end else if (word_valid && rx_reg[`LSW_WD_BIT] != last_wd_reg) begin
      wd_cnt_reg <= 32'h00000000;
    end else if (wd_cnt_reg >= 32'(WATCHDOG_TIMEOUT_PERIOD_CYC - 1)) begin
      wd_to_reg <= 1'b1;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + 32'h00000001;
    end
  end

  // --------------------------------------------------
  // mode control
  // --------------------------------------------------
  assign fail_cond = (VDD_FAIL & vdd_en_reg) | (wd_to_reg & FAILSAFE_STRAP_PIN);
  assign exit_req  = word_valid && rx_reg[`LSW_EXIT_BIT] && !VDD_FAIL;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      LSW_SLEEP: begin
        if (wake) mode_next = LSW_NORMAL;
      end
      LSW_NORMAL: begin
        if (!wake) mode_next = LSW_SLEEP;
        else if (fail_cond && !fail_d_reg) mode_next = LSW_FAILSAFE;
      end
      LSW_FAILSAFE: begin
        if (!wake) mode_next = LSW_SLEEP;
        else if (exit_req || (fs_wd_reg && !FAILSAFE_STRAP_PIN)) mode_next = LSW_NORMAL;
      end
      default: mode_next = LSW_SLEEP;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg   <= LSW_SLEEP;
      fail_d_reg <= 1'b0;
      fs_wd_reg  <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      fail_d_reg <= fail_cond;
      if (mode_reg == LSW_NORMAL && mode_next == LSW_FAILSAFE)
        fs_wd_reg <= wd_to_reg & FAILSAFE_STRAP_PIN;
    end
  end

  assign NORMAL_MODE_FLAG = (mode_reg == LSW_NORMAL);

  // --------------------------------------------------
  // fault report register
  // --------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      oc_rep_reg <= 4'h0;
      ot_rep_reg <= 4'h0;
      ol_rep_reg <= 4'h0;
      uv_rep_reg <= 1'b0;
      ov_rep_reg <= 1'b0;
    end else if (mode_reg == LSW_SLEEP) begin
      oc_rep_reg <= 4'h0;
      ot_rep_reg <= 4'h0;
      ol_rep_reg <= 4'h0;
      uv_rep_reg <= wake;
      ov_rep_reg <= 1'b0;
    end else begin
      // a flag arriving during the clearing transfer survives
      oc_rep_reg <= (oc_rep_reg & {4{~word_valid}}) | OVERCURRENT_FLAG | SEVERE_SHORT_FLAG;
      ot_rep_reg <= (ot_rep_reg & {4{~word_valid}}) | OVERTEMP_FLAG;
      ol_rep_reg <= (ol_rep_reg & {4{~word_valid}}) | OPEN_LOAD_ON_FLAG;
      uv_rep_reg <= (uv_rep_reg & ~word_valid) | BATTERY_LOW_FLAG;
      ov_rep_reg <= (ov_rep_reg & ~word_valid) | SUPPLY_HIGH_FLAG;
    end
  end

  // --------------------------------------------------
  // latched output faults and rearm
  // --------------------------------------------------
  assign hard_flt = OVERCURRENT_FLAG | OVERTEMP_FLAG | SEVERE_SHORT_FLAG | {4{BATTERY_LOW_FLAG}};
  assign rearm = on_reg | (LAMP_REQUEST_PINS & ~dis_reg & {4{~pwm_en_reg}});

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) rearm_d_reg <= 4'h0;
    else rearm_d_reg <= rearm;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 4'h0;
    end else if (mode_reg == LSW_SLEEP || (mode_reg != mode_next && mode_next != LSW_SLEEP)) begin
      latch_reg <= 4'h0;
    end else begin
      // set wins over a rearm in the same cycle
      latch_reg <= (latch_reg & ~(rearm & ~rearm_d_reg)) | (hard_flt & cmd);
    end
  end

  assign fault_cond = |OVERCURRENT_FLAG | |OVERTEMP_FLAG | |SEVERE_SHORT_FLAG |
                      BATTERY_LOW_FLAG | (SUPPLY_HIGH_FLAG & supply_high_protect_disable_reg);

  // --------------------------------------------------
  // PWM module
  // --------------------------------------------------
  lsw_pwm_clk #(
    .CAL_MIN (CAL_MIN_CYC),
    .CAL_MAX (CAL_MAX_CYC)
  ) u_pwm_clk (
    .clk      (CLK),
    .rst_n    (rst_n),
    .ext_clk  (LAMP_REQUEST_PINS[0]),
    .clk_sel  (clk_sel_reg),
    .cs_n     (SPI_CS_N),
    .cal_arm  (cal_arm),
    .tick     (pwm_tick),
    .phase    (pwm_phase),
    .clk_fail (clk_fail)
  );

  for (genvar i = 0; i < 4; i++) begin : g_chan
    lsw_pwm_chan u_chan (
      .clk   (CLK),
      .rst_n (rst_n),
      .tick  (pwm_tick),
      .phase (pwm_phase),
      .duty  (duty_reg[i]),
      .delay (dly_reg[i]),
      .wave  (wave[i])
    );
  end

  assign pwm_act = pwm_en_reg & ~(clk_fail & ~clk_sel_reg);

  // --------------------------------------------------
  // output command and pins
  // --------------------------------------------------
  always_comb begin
    case (mode_reg)
      LSW_NORMAL: begin
        if (pwm_act) cmd = on_reg & wave;
        else cmd = (LAMP_REQUEST_PINS & ~dis_reg) | on_reg;
      end
      LSW_FAILSAFE: cmd = LAMP_REQUEST_PINS;
      default: cmd = 4'h0;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) LAMP_OUTPUTS <= 4'h0;
    else if (!ready || (SUPPLY_HIGH_FLAG && !supply_high_protect_disable_reg)) LAMP_OUTPUTS <= 4'h0;
    else LAMP_OUTPUTS <= cmd & ~latch_reg & ~hard_flt;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) FAULT_FLAG_PIN_OE_N <= 1'b1;
    else FAULT_FLAG_PIN_OE_N <= !(mode_reg != LSW_SLEEP &&
                                  (fault_cond || |latch_reg || SUPPLY_HIGH_FLAG));
  end

  assign FAULT_FLAG_PIN_O = 1'b0;
endmodule

// file: hw/lsw_consts.svh
// constants of the lamp switch control core
//
// Overview of operation
// - 16-bit full-duplex SPI words, MSB first
// - wake-up is OR of reset, wake, requests
// - fail on supply loss or watchdog timeout
// - fault on any protection flag set
// - sleep when wake-up low; all cleared
// - normal mode output equation and flag
// - rearm signal clears latched output faults
// - PWM period is 128 PWM clocks
// - duty code n gives (n+1)/128 on-time
// - per-output delay of code times sixteen
// - external clock failure stops PWM, reported
// - chip-select low pulse calibrates internal clock
// - out-of-range calibration pulse is ignored
// - select bit chooses internal PWM clock
// - watchdog armed by rising wake sources
// - fail-safe outputs follow requests, config cleared
// - exit word, or grounded strap after watchdog entry, leaves fail-safe
// - enter fail-safe only when fail rises
// - fault pin low while fault; latches held
// - fault report cleared by valid transfer
// - startup delay, registers zero, undervoltage reported
// - received word committed on chip-select rise
// - status loaded on chip-select fall
// - sample on clock fall, shift on rise
`ifndef LSW_CONSTS_SVH
`define LSW_CONSTS_SVH
`define LSW_WORD_W      16
`define LSW_WD_BIT      15
`define LSW_ADDR_HI     14
`define LSW_ADDR_LO     12
`define LSW_EXIT_BIT    7
`define LSW_A_CTRL      3'h0
`define LSW_A_DUTY0     3'h1
`define LSW_A_CAL       3'h5
`define LSW_CAL_KEY     12'hCA1
`define LSW_F_ON        0
`define LSW_F_DIS       4
`define LSW_F_PWM_EN    8
`define LSW_F_CLK_SEL   9
`define LSW_F_VDD_EN    10
`define LSW_F_SUPPLY_HIGH_PROTECT_DISABLE    11
`define LSW_F_DUTY      0
`define LSW_F_DLY       7
`define LSW_S_NM        15
`define LSW_S_CF        14
`define LSW_S_UV        13
`define LSW_S_OV        12
`define LSW_S_OC        8
`define LSW_S_OT        4
`define LSW_S_OL        0
`define LSW_CLK_MHZ     100
`define LSW_STARTUP_US  50
`define LSW_STARTUP_CYC (`LSW_STARTUP_US * `LSW_CLK_MHZ)
`define LSW_WATCHDOG_TIMEOUT_PERIOD_US     10000
`define LSW_WATCHDOG_TIMEOUT_PERIOD_CYC    (`LSW_WATCHDOG_TIMEOUT_PERIOD_US * `LSW_CLK_MHZ)
`define LSW_EXT_MIN_CYC 1953
`define LSW_EXT_MAX_CYC 7812
`define LSW_INT_DEF_CYC 3906
`define LSW_CAL_MIN_CYC 350000
`define LSW_CAL_MAX_CYC 650000
`define LSW_DLY_SHIFT   4
`endif

// file: hw/lsw_pkg.sv
// types of the lamp switch control core
package lsw_pkg;
  typedef enum logic [1:0] {
    LSW_SLEEP    = 2'b00,
    LSW_NORMAL   = 2'b01,
    LSW_FAILSAFE = 2'b10
  } lsw_mode_t;
endpackage

// file: hw/lsw_pwm_chan.sv
// one PWM output channel with switching delay
`timescale 1ns/1ps
`include "lsw_consts.svh"
module lsw_pwm_chan import lsw_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic [6:0] phase,
  input  wire logic [6:0] duty,
  input  wire logic [2:0] delay,
  output logic            wave
);
  logic [6:0] duty_reg;
  logic [2:0] dly_reg;
  logic [6:0] pos;

  // phase after this tick, shifted back by the delay
  assign pos = 7'(phase + 7'h01 - {dly_reg, 4'h0});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_reg <= 7'h00;
      dly_reg  <= 3'h0;
    end else if (tick && phase == 7'h7F) begin
      duty_reg <= duty;
      dly_reg  <= delay;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wave <= 1'b0;
    else if (tick) wave <= (pos <= duty_reg);
  end
endmodule

// file: hw/lsw_pwm_clk.sv
// PWM clock source, monitor and calibration
`timescale 1ns/1ps
`include "lsw_consts.svh"
module lsw_pwm_clk import lsw_pkg::*; #(
  parameter int CAL_MIN = `LSW_CAL_MIN_CYC,
  parameter int CAL_MAX = `LSW_CAL_MAX_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ext_clk,
  input  wire logic       clk_sel,
  input  wire logic       cs_n,
  input  wire logic       cal_arm,
  output logic            tick,
  output logic [6:0]      phase,
  output logic            clk_fail
);
  logic        ext_d_reg;
  logic        ext_rise;
  logic [12:0] ext_cnt_reg;
  logic [15:0] int_cnt_reg;
  logic [15:0] int_per_reg;
  logic        int_tick;
  logic        cs_d_reg;
  logic        cal_wait_reg;
  logic        cal_meas_reg;
  logic [19:0] cal_cnt_reg;
  logic        sel_reg;

  assign ext_rise = ext_clk & ~ext_d_reg;
  assign int_tick = (int_cnt_reg >= int_per_reg - 16'h0001);
  assign tick     = sel_reg ? int_tick : ext_rise;

  // --------------------------------------------------
  // external clock period monitor
  // --------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_d_reg   <= 1'b0;
      ext_cnt_reg <= 13'h0000;
      clk_fail    <= 1'b1;
    end else begin
      ext_d_reg <= ext_clk;
      if (ext_rise) begin
        ext_cnt_reg <= 13'h0000;
        clk_fail    <= (ext_cnt_reg < 13'(`LSW_EXT_MIN_CYC)) ||
                       (ext_cnt_reg > 13'(`LSW_EXT_MAX_CYC));
      end else if (ext_cnt_reg <= 13'(`LSW_EXT_MAX_CYC)) begin
        ext_cnt_reg <= ext_cnt_reg + 13'h0001;
      end else begin
        clk_fail <= 1'b1;
      end
    end
  end

  // --------------------------------------------------
  // internal oscillator and chip-select calibration
  // --------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt_reg  <= 16'h0000;
      int_per_reg  <= 16'(`LSW_INT_DEF_CYC);
      cs_d_reg     <= 1'b1;
      cal_wait_reg <= 1'b0;
      cal_meas_reg <= 1'b0;
      cal_cnt_reg  <= 20'h00000;
    end else begin
      cs_d_reg    <= cs_n;
      int_cnt_reg <= int_tick ? 16'h0000 : int_cnt_reg + 16'h0001;
      if (cal_arm) cal_wait_reg <= 1'b1;
      if (cal_wait_reg && cs_d_reg && !cs_n) begin
        cal_wait_reg <= 1'b0;
        cal_meas_reg <= 1'b1;
        // the first low sample already counts toward the width
        cal_cnt_reg  <= 20'h00001;
      end else if (cal_meas_reg && cs_n) begin
        cal_meas_reg <= 1'b0;
        if (cal_cnt_reg >= 20'(CAL_MIN) && cal_cnt_reg <= 20'(CAL_MAX))
          int_per_reg <= {3'h0, cal_cnt_reg[19:7]};
      end else if (cal_meas_reg && cal_cnt_reg != 20'hFFFFF) begin
        cal_cnt_reg <= cal_cnt_reg + 20'h00001;
      end
    end
  end

  // --------------------------------------------------
  // 128-step period counter, source change at boundary or on external clock failure
  // --------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase   <= 7'h00;
      sel_reg <= 1'b0;
    end else begin
      if (tick) phase <= phase + 7'h01;
      if ((tick && phase == 7'h7F) || (!sel_reg && clk_fail))
        sel_reg <= clk_sel;
    end
  end
endmodule

// file: tb/lsw_core_sva.sv
// port checker of the lamp switch core
`timescale 1ns/1ps
module lsw_core_sva (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       SPI_CS_N,
  input wire logic       SPI_SO_OE_N,
  input wire logic       RESET_WAKE_PIN,
  input wire logic       WAKE_PIN,
  input wire logic [3:0] LAMP_REQUEST_PINS,
  input wire logic [3:0] OVERTEMP_FLAG,
  input wire logic [3:0] LAMP_OUTPUTS,
  input wire logic       FAULT_FLAG_PIN_O,
  input wire logic       FAULT_FLAG_PIN_OE_N,
  input wire logic       NORMAL_MODE_FLAG
);
  logic wake;
  assign wake = RESET_WAKE_PIN | WAKE_PIN | (|LAMP_REQUEST_PINS);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_so_drive_cs: assert property (SPI_SO_OE_N == SPI_CS_N)
    else $error("serial out enable differs from chip select");
  a_fault_od_low: assert property (FAULT_FLAG_PIN_O == 1'h0)
    else $error("fault pin data not low");
  a_sleep_dark: assert property (!wake [*3] |-> LAMP_OUTPUTS == 4'h0 && !NORMAL_MODE_FLAG)
    else $error("outputs or normal flag active in sleep");
  a_normal_needs_wake: assert property (NORMAL_MODE_FLAG |-> $past(wake) || $past(wake, 2))
    else $error("normal mode without wake source");
  a_fault_pin_low: assert property ((NORMAL_MODE_FLAG && |OVERTEMP_FLAG) [*3] |-> !FAULT_FLAG_PIN_OE_N)
    else $error("fault pin released during fault");
  a_ot_output_off: assert property (OVERTEMP_FLAG[0] [*3] |-> !LAMP_OUTPUTS[0])
    else $error("output on during overtemperature");
  a_reset_quiet: assert property ($rose(RSTN) |-> LAMP_OUTPUTS == 4'h0 && FAULT_FLAG_PIN_OE_N)
    else $error("outputs active at reset release");
  a_startup_off: assert property ($rose(NORMAL_MODE_FLAG) && !$past(wake, 3) |=> (LAMP_OUTPUTS == 4'h0) [*8])
    else $error("output on during start-up");
  c_normal: cover property ($rose(NORMAL_MODE_FLAG));
  c_fault: cover property ($fell(FAULT_FLAG_PIN_OE_N));
  c_failsafe: cover property (wake && !NORMAL_MODE_FLAG && |LAMP_OUTPUTS);
endmodule
bind lsw_core lsw_core_sva chk (.*);

// file: tb/lsw_host.sv
// host model driving the serial port
`timescale 1ns/1ps
module lsw_host (
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    si   = 1'h0;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge clk);
    cs_n <= 1'h0;
    repeat (4) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      si   <= w[i];
      sclk <= 1'h1;
      repeat (4) @(posedge clk);
      r[i] = so;
      sclk <= 1'h0;
      repeat (4) @(posedge clk);
    end
    cs_n <= 1'h1;
    si   <= ~w[0];
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    cs_n <= 1'h0;
    repeat (n) @(posedge clk);
    cs_n <= 1'h1;
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: tb/tb_top.sv
// testbench of the lamp switch core
`timescale 1ns/1ps
module tb_top;
  logic        CLK, RSTN, cs_n, sclk, si, so, so_oe_n, rwake, wake, strap;
  logic        vdd_fail, bat_low, sup_high, fo, fo_oe_n, nm, wd;
  logic [3:0]  req, oc, ot, sc, ol, outs;
  logic [15:0] r;
  int          n_errors = 0;
  int          n_compared = 0;
  int          k, m;
  lsw_host host (.clk(CLK), .so(so), .cs_n(cs_n), .sclk(sclk), .si(si));
  lsw_core #(.STARTUP_CYC(20), .WATCHDOG_TIMEOUT_PERIOD_CYC(200), .CAL_MIN_CYC(1280), .CAL_MAX_CYC(2560)) DUT (
    .CLK(CLK), .RSTN(RSTN), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_SI(si),
    .SPI_SO(so), .SPI_SO_OE_N(so_oe_n), .RESET_WAKE_PIN(rwake), .WAKE_PIN(wake),
    .LAMP_REQUEST_PINS(req), .FAILSAFE_STRAP_PIN(strap), .VDD_FAIL(vdd_fail),
    .OVERCURRENT_FLAG(oc), .OVERTEMP_FLAG(ot), .SEVERE_SHORT_FLAG(sc),
    .OPEN_LOAD_ON_FLAG(ol), .BATTERY_LOW_FLAG(bat_low), .SUPPLY_HIGH_FLAG(sup_high),
    .LAMP_OUTPUTS(outs), .FAULT_FLAG_PIN_O(fo), .FAULT_FLAG_PIN_OE_N(fo_oe_n),
    .NORMAL_MODE_FLAG(nm)
  );
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    host.xfer({wd, a, d}, r);
    wd = ~wd;
    repeat (6) @(posedge CLK);
  endtask
  task automatic wait0(input logic v);
    k = 0;
    while (outs[0] !== v && k < 5000) begin
      @(posedge CLK);
      k++;
    end
    if (k >= 5000) n_errors++;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge CLK);
    n_errors++;
    stop_test();
  end
  initial begin
    {RSTN, rwake, wake, strap, vdd_fail, bat_low, sup_high, req, oc, ot, sc, ol} = '0;
    wd = 1'h1;
    repeat (10) @(posedge CLK);
    RSTN <= 1'h1;
    repeat (4) @(posedge CLK);
    chk({nm, fo_oe_n, outs}, 16'h0010);
    $display("test sleep done");
    rwake <= 1'h1;
    repeat (30) @(posedge CLK);
    chk(nm, 16'h0001);
    wr(3'h0, 12'h005);
    chk(r[15:13], 16'h0007);
    chk(outs, 16'h0005);
    req <= 4'hA;
    repeat (4) @(posedge CLK);
    chk(outs, 16'h000F);
    wr(3'h0, 12'h0A5);
    chk({r[13], outs}, 16'h0005);
    req <= 4'h0;
    $display("test normal done");
    ot <= 4'h1;
    repeat (4) @(posedge CLK);
    chk({fo_oe_n, outs}, 16'h0004);
    ot <= 4'h0;
    repeat (4) @(posedge CLK);
    chk({fo_oe_n, outs}, 16'h0004);
    wr(3'h0, 12'h004);
    chk(r[4], 16'h0001);
    wr(3'h0, 12'h005);
    chk({fo_oe_n, outs}, 16'h0015);
    sup_high <= 1'h1;
    repeat (4) @(posedge CLK);
    chk({fo_oe_n, outs}, 16'h0000);
    sup_high <= 1'h0;
    repeat (4) @(posedge CLK);
    chk({fo_oe_n, outs}, 16'h0015);
    $display("test fault done");
    wr(3'h5, 12'hCA1);
    host.pulse(1280);
    wr(3'h1, 12'h01F);
    req <= 4'h2;
    wr(3'h0, 12'h301);
    wait0(1'h1);
    wait0(1'h0);
    wait0(1'h1);
    m = 0;
    repeat (1280) begin
      @(posedge CLK);
      m += outs[0];
    end
    chk(m[15:0], 16'h0140);
    chk(outs[1], 16'h0000);
    $display("test pwm done");
    req <= 4'h0;
    strap <= 1'h1;
    repeat (3) @(posedge CLK);
    req <= 4'h2;
    repeat (260) @(posedge CLK);
    chk({nm, outs}, 16'h0002);
    wr(3'h0, 12'h080);
    chk(nm, 16'h0001);
    repeat (250) @(posedge CLK);
    chk({nm, outs}, 16'h0002);
    strap <= 1'h0;
    repeat (4) @(posedge CLK);
    chk(nm, 16'h0001);
    $display("test failsafe done");
    stop_test();
  end
endmodule
